/* core/smc_top.sv */
// supply monitor control: register port, reset request and interrupt
//
// Behaviour
// - monitor inactive after reset until enabled
// - clearing power disable starts comparator tracking
// - reset disable clear: low supply requests reset
// - stop enable keeps monitor running in stop
// - two-bit field selects 5V or 3.3V range
// - held reset releases above rising trip or when the monitor goes inactive
// - held reset also drives reset pin low
// - flag: set below fall, clear above rise
// - flag read-only, cleared by reset
// - flag toggle sets irq flag; enable gates request
// - writing one to ack clears irq flag
// - reset wins over interrupt, clears enable
// - irq enable read/write, cleared by reset
// - irq flag read-only, cleared by reset
// - ack bit write-only, reads zero
// - in wait monitor active, can wake
// - in stop active only with stop enable
`timescale 1ns/1ns
`default_nettype none
module smc_top (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // register port
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output var  logic [7:0] o_rdata,
  // analog comparator, asynchronous levels
  input  wire logic       i_cmp_below_fall,
  input  wire logic       i_cmp_above_rise,
  // low-power mode status from the core
  input  wire logic       i_wait_mode,
  input  wire logic       i_stop_mode,
  // comparator controls
  output logic            o_cmp_enable,
  output logic [1:0]      o_trip_range_select,
  // system side
  output logic            o_reset_req,
  output logic            o_rst_pin_n_out,
  output logic            o_rst_pin_oe,
  output logic            o_irq,
  output logic            o_wakeup
);
  logic       monitor_power_disable;
  logic       monitor_reset_disable;
  logic       monitor_stop_enable;
  logic [1:0] trip_range_select;
  logic       supply_irq_enable;
  logic       supply_irq_flag;
  logic       supply_low_flag;
  logic       low_toggle;
  logic       reset_held;
  logic       below_sync;
  logic       above_sync;
  logic       monitor_active;
  logic       ack_write;
  logic       reset_trip;
  logic       status_write;
  logic [1:0] cmp_async;
  logic [1:0] cmp_sync;

  // one decode shared by every register write strobe
  function automatic logic reg_hit(
    input logic       strobe,
    input logic [1:0] addr,
    input logic [1:0] offset
  );
    return strobe && (addr == offset);
  endfunction : reg_hit

  // config words
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      monitor_power_disable <= smc_pkg::RST_CONFIG_ONE[smc_pkg::BIT_PWR_DIS];
      monitor_reset_disable <= smc_pkg::RST_CONFIG_ONE[smc_pkg::BIT_RST_DIS];
      monitor_stop_enable   <= smc_pkg::RST_CONFIG_ONE[smc_pkg::BIT_STOP_EN];
    end else if (reg_hit(i_wr, i_addr, smc_pkg::OFF_CONFIG_ONE)) begin
      monitor_power_disable <= i_wdata[smc_pkg::BIT_PWR_DIS];
      monitor_reset_disable <= i_wdata[smc_pkg::BIT_RST_DIS];
      monitor_stop_enable   <= i_wdata[smc_pkg::BIT_STOP_EN];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trip_range_select <= smc_pkg::RST_RANGE;
    end else if (reg_hit(i_wr, i_addr, smc_pkg::OFF_CONFIG_TWO)) begin
      trip_range_select <= i_wdata[smc_pkg::BIT_RANGE_LO +: 2];
    end
  end

  // monitor runs in run and wait; in stop only with stop enable
  assign monitor_active = !monitor_power_disable && (!i_stop_mode || monitor_stop_enable);
  assign o_cmp_enable        = monitor_active;
  assign o_trip_range_select = trip_range_select;

  assign cmp_async = {i_cmp_above_rise, i_cmp_below_fall};

  // one synchroniser per comparator level
  for (genvar g = 0; g < 2; g++) begin : g_cmp_sync
    smc_sync #(.RESET_VAL(1'b0)) u_sync (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_async (cmp_async[g]),
      .o_level (cmp_sync[g])
    );
  end

  assign below_sync = cmp_sync[0];
  assign above_sync = cmp_sync[1];

  smc_hyst u_hyst (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_enable     (monitor_active),
    .i_below_fall (below_sync),
    .i_above_rise (above_sync),
    .o_low        (supply_low_flag),
    .o_toggle     (low_toggle)
  );

  // held reset: set on low with resets enabled, released above rising trip
  assign reset_trip = monitor_active && !monitor_reset_disable && below_sync;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reset_held <= 1'b0;
    end else if (reset_trip) begin
      reset_held <= 1'b1;
    end else if (above_sync || !monitor_active) begin
      reset_held <= 1'b0;
    end
  end

  assign o_reset_req     = reset_held;
  assign o_rst_pin_n_out = 1'b0;
  assign o_rst_pin_oe    = reset_held;

  assign status_write = reg_hit(i_wr, i_addr, smc_pkg::OFF_STATUS);
  assign ack_write    = status_write && i_wdata[smc_pkg::BIT_IRQ_ACK];

  // interrupt flag: toggle sets, ack clears, set wins
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      supply_irq_flag <= 1'b0;
    end else if (low_toggle) begin
      supply_irq_flag <= 1'b1;
    end else if (ack_write) begin
      supply_irq_flag <= 1'b0;
    end
  end

  // the trip itself clears the enable, so the enable is gone when the reset appears
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      supply_irq_enable <= 1'b0;
    end else if (reset_held || reset_trip) begin
      supply_irq_enable <= 1'b0;
    end else if (status_write) begin
      supply_irq_enable <= i_wdata[smc_pkg::BIT_IRQ_ENABLE];
    end
  end

  assign o_irq    = supply_irq_flag && supply_irq_enable && !reset_held;
  assign o_wakeup = o_irq || reset_held;

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        smc_pkg::OFF_STATUS: begin
          o_rdata <= {supply_low_flag, supply_irq_flag, 4'h0, supply_irq_enable, 1'b0};
        end
        smc_pkg::OFF_CONFIG_ONE: begin
          o_rdata <= {5'h00, monitor_stop_enable, monitor_reset_disable, monitor_power_disable};
        end
        smc_pkg::OFF_CONFIG_TWO: begin
          o_rdata <= {6'h00, trip_range_select};
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // assertions
  property p_irq_set;
    @(posedge i_clock) disable iff (!i_rst_n) low_toggle |=> supply_irq_flag;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq flag not set on toggle");

  property p_ack_clear;
    @(posedge i_clock) disable iff (!i_rst_n) (ack_write && !low_toggle) |=> !supply_irq_flag;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear flag");

  property p_reset_pin;
    @(posedge i_clock) disable iff (!i_rst_n) o_reset_req |-> o_rst_pin_oe && !o_rst_pin_n_out;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin not driven low");

  property p_reset_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
      (reset_held && monitor_active && !above_sync) |=> reset_held;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset released early");

  property p_reset_trip;
    @(posedge i_clock) disable iff (!i_rst_n)
      (monitor_active && !monitor_reset_disable && below_sync) |=> o_reset_req ##0 !supply_irq_enable;
  endproperty
  a_reset_trip: assert property (p_reset_trip) else $error("no reset on low supply");

  property p_no_irq_in_reset;
    @(posedge i_clock) disable iff (!i_rst_n) reset_held |-> !o_irq;
  endproperty
  a_no_irq_in_reset: assert property (p_no_irq_in_reset) else $error("irq during reset");

  property p_ack_reads_zero;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rd && i_addr == smc_pkg::OFF_STATUS) |=> !o_rdata[smc_pkg::BIT_IRQ_ACK];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read nonzero");

  property p_flag_low;
    @(posedge i_clock) disable iff (!i_rst_n) (monitor_active && below_sync) |=> supply_low_flag;
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("low flag not set");

  property p_flag_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
      (!below_sync && !above_sync) |=> $stable(supply_low_flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("low flag moved between trips");

  property p_stop_idle;
    @(posedge i_clock) disable iff (!i_rst_n) (i_stop_mode && !monitor_stop_enable) |-> !o_cmp_enable;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("monitor active in stop");

  property p_power_off;
    @(posedge i_clock) disable iff (!i_rst_n)
      monitor_power_disable |-> !o_cmp_enable;
  endproperty
  a_power_off: assert property (p_power_off) else $error("comparator enabled while powered down");

  property p_power_on;
    @(posedge i_clock) disable iff (!i_rst_n)
      (!monitor_power_disable && !i_stop_mode) |-> o_cmp_enable;
  endproperty
  a_power_on: assert property (p_power_on) else $error("comparator not enabled");

  property p_wait_active;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_wait_mode && !i_stop_mode && !monitor_power_disable) |-> o_cmp_enable;
  endproperty
  a_wait_active: assert property (p_wait_active) else $error("monitor idle in wait");

  property p_stop_active;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_stop_mode && monitor_stop_enable && !monitor_power_disable) |-> o_cmp_enable;
  endproperty
  a_stop_active: assert property (p_stop_active) else $error("monitor idle in enabled stop");

  property p_flag_frozen;
    @(posedge i_clock) disable iff (!i_rst_n)
      !monitor_active |=> $stable(supply_low_flag);
  endproperty
  a_flag_frozen: assert property (p_flag_frozen) else $error("low flag moved while monitor off");

  property p_flag_clear;
    @(posedge i_clock) disable iff (!i_rst_n)
      (monitor_active && above_sync && !below_sync) |=> !supply_low_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("low flag not cleared above rise");

  property p_irq_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
      (!low_toggle && !ack_write) |=> $stable(supply_irq_flag);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq flag moved without toggle or ack");

  property p_ack_zero_kept;
    @(posedge i_clock) disable iff (!i_rst_n)
      (status_write && !i_wdata[smc_pkg::BIT_IRQ_ACK] && supply_irq_flag) |=> supply_irq_flag;
  endproperty
  a_ack_zero_kept: assert property (p_ack_zero_kept) else $error("ack zero cleared flag");

  property p_irq_raise;
    @(posedge i_clock) disable iff (!i_rst_n)
      (supply_irq_flag && supply_irq_enable && !reset_held) |-> o_irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq request missing");

  property p_irq_gate;
    @(posedge i_clock) disable iff (!i_rst_n)
      !supply_irq_enable |-> !o_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq request while disabled");

  property p_enable_set;
    @(posedge i_clock) disable iff (!i_rst_n)
      (status_write && i_wdata[smc_pkg::BIT_IRQ_ENABLE] && !reset_held && !reset_trip) |=> supply_irq_enable;
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("irq enable not written");

  property p_enable_cleared;
    @(posedge i_clock) disable iff (!i_rst_n)
      reset_held |=> !supply_irq_enable;
  endproperty
  a_enable_cleared: assert property (p_enable_cleared) else $error("irq enable kept during reset");

  property p_no_reset_disabled;
    @(posedge i_clock) disable iff (!i_rst_n)
      (monitor_reset_disable && !reset_held) |=> !o_reset_req;
  endproperty
  a_no_reset_disabled: assert property (p_no_reset_disabled) else $error("reset while resets disabled");

  property p_reset_release;
    @(posedge i_clock) disable iff (!i_rst_n)
      (reset_held && above_sync && !below_sync) |=> !o_reset_req;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset kept above rise");

  property p_pin_idle;
    @(posedge i_clock) disable iff (!i_rst_n)
      !o_reset_req |-> !o_rst_pin_oe;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("reset pin driven without reset");

  property p_status_read;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_rd && i_addr == smc_pkg::OFF_STATUS) |=> o_rdata[smc_pkg::BIT_LOW_FLAG] == $past(supply_low_flag);
  endproperty
  a_status_read: assert property (p_status_read) else $error("low flag read wrong");

  property p_wake;
    @(posedge i_clock) disable iff (!i_rst_n)
      (o_irq || o_reset_req) |-> o_wakeup;
  endproperty
  a_wake: assert property (p_wake) else $error("no wakeup on request");
endmodule : smc_top
`default_nettype wire

/* core/smc_pkg.sv */
// shared constants for the supply monitor control block
package smc_pkg;
  // register port
  localparam int          ADDR_W          = 2;
  localparam logic [1:0]  OFF_STATUS      = 2'h0;
  localparam logic [1:0]  OFF_CONFIG_ONE  = 2'h1;
  localparam logic [1:0]  OFF_CONFIG_TWO  = 2'h2;
  // status register fields
  localparam int          BIT_LOW_FLAG    = 7;
  localparam int          BIT_IRQ_FLAG    = 6;
  localparam int          BIT_IRQ_ENABLE  = 1;
  localparam int          BIT_IRQ_ACK     = 0;
  // config word one fields
  localparam int          BIT_STOP_EN     = 2;
  localparam int          BIT_RST_DIS     = 1;
  localparam int          BIT_PWR_DIS     = 0;
  // config word two fields
  localparam int          BIT_RANGE_LO    = 0;
  // reset values
  localparam logic [7:0]  RST_STATUS      = 8'h00;
  localparam logic [7:0]  RST_CONFIG_ONE  = 8'h03;
  localparam logic [1:0]  RST_RANGE       = 2'h0;
  // trip range encodings
  localparam logic [1:0]  RANGE_5V        = 2'h0;
  localparam logic [1:0]  RANGE_3V3       = 2'h1;
endpackage : smc_pkg

/* core/smc_sync.sv */
// three-stage synchroniser with agreement filter for one level
`timescale 1ns/1ns
`default_nettype none
module smc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // level
  input  wire logic i_async,
  output var  logic o_level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // output moves only when stages two and three agree
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= RESET_VAL;
    end else if (s2 == s3) begin
      o_level <= s3;
    end
  end
endmodule : smc_sync
`default_nettype wire

/* core/smc_hyst.sv */
// hysteretic supply-low flag with toggle detect
`timescale 1ns/1ns
`default_nettype none
module smc_hyst (
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  // monitor enable and synchronised comparator levels
  input  wire logic i_enable,
  input  wire logic i_below_fall,
  input  wire logic i_above_rise,
  // flag and change pulse
  output var  logic o_low,
  output logic      o_toggle
);
  logic next_low;

  always_comb begin
    next_low = o_low;
    if (i_enable && i_below_fall) begin
      next_low = 1'b1;
    end else if (i_enable && i_above_rise) begin
      next_low = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_low <= 1'b0;
    end else begin
      o_low <= next_low;
    end
  end

  assign o_toggle = next_low != o_low;
endmodule : smc_hyst
`default_nettype wire

/* verification/smc_supply_model.sv */
// behavioural supply comparator driven by a coarse supply level
`timescale 1ns/1ns
`default_nettype none
module smc_supply_model (
  // control
  input  wire logic       i_enable,
  input  wire logic [1:0] i_level,
  // comparator levels
  output logic            o_below_fall,
  output logic            o_above_rise
);
  // level 0 above rise, 1 inside the band, 2 below fall; both low when powered down
  assign o_below_fall = i_enable & (i_level == 2'h2);
  assign o_above_rise = i_enable & (i_level == 2'h0);
endmodule : smc_supply_model
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the supply monitor control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [7:0] k_low = 8'h01 << smc_pkg::BIT_LOW_FLAG;
  localparam logic [7:0] k_flg = 8'h01 << smc_pkg::BIT_IRQ_FLAG;
  localparam logic [7:0] k_ie  = 8'h01 << smc_pkg::BIT_IRQ_ENABLE;
  localparam logic [7:0] k_ack = 8'h01 << smc_pkg::BIT_IRQ_ACK;
  localparam logic [7:0] k_rsd = 8'h01 << smc_pkg::BIT_RST_DIS;
  localparam logic [7:0] k_stp = 8'h01 << smc_pkg::BIT_STOP_EN;
  logic       i_clock = 1'b0;
  logic       i_rst_n, i_wr, i_rd, i_wait_mode, i_stop_mode;
  logic       rd_q = 1'b0;
  logic [1:0] i_addr, level, range;
  logic [7:0] i_wdata, o_rdata;
  logic       below, above, cmp_en, rst_req, pin_n, pin_oe, irq, wake;
  logic [7:0] exp_q[$];
  int         failures, tests_run, seed, n;

  always #2 i_clock = ~i_clock;

  smc_top smc_top_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_below_fall(below), .i_cmp_above_rise(above),
    .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode), .o_cmp_enable(cmp_en),
    .o_trip_range_select(range), .o_reset_req(rst_req), .o_rst_pin_n_out(pin_n),
    .o_rst_pin_oe(pin_oe), .o_irq(irq), .o_wakeup(wake));
  smc_supply_model smc_supply_model_inst (.i_enable(cmp_en), .i_level(level),
    .o_below_fall(below), .o_above_rise(above));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_clock);
    i_rd   <= 1'b0;
  endtask : rd

  // comparator path latency is a handful of cycles, so eight is ample
  task automatic settle();
    repeat (8) @(posedge i_clock);
  endtask : settle

  task automatic complete_run();
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // read data stand only in the cycle after the strobe
  always @(posedge i_clock) begin
    if (rd_q) begin
      if (exp_q.size() == 0) check("rdata_unexpected", o_rdata, 8'h00);
      else check("rdata", o_rdata, exp_q.pop_front());
    end
    rd_q <= i_rd;
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    failures++;
    complete_run();
  end

  initial begin
    seed = 32'ha0d601c9;
    {i_rst_n, i_wr, i_rd, i_wait_mode, i_stop_mode} = '0;
    i_addr  = '0;
    i_wdata = '0;
    level   = 2'h0;
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(smc_pkg::OFF_STATUS, smc_pkg::RST_STATUS);
    rd(smc_pkg::OFF_CONFIG_ONE, smc_pkg::RST_CONFIG_ONE);
    rd(smc_pkg::OFF_CONFIG_TWO, {6'h0, smc_pkg::RST_RANGE});
    check("cmp_enable", {7'h0, cmp_en}, 8'h00);
    for (n = 0; n < 4; n++) begin
      wr(2'h3, 8'($random(seed)));
      rd(2'h3, 8'h00);
      wr(smc_pkg::OFF_CONFIG_TWO, 8'(n));
      rd(smc_pkg::OFF_CONFIG_TWO, 8'(n));
      check("range", {6'h0, range}, 8'(n));
    end
    wr(smc_pkg::OFF_CONFIG_TWO, {6'h0, smc_pkg::RANGE_3V3});
    wr(smc_pkg::OFF_CONFIG_ONE, k_rsd);
    wr(smc_pkg::OFF_STATUS, k_ie);
    i_wait_mode <= 1'b1;
    rd(smc_pkg::OFF_STATUS, k_ie);
    check("cmp_enable", {7'h0, cmp_en}, 8'h01);
    level <= 2'h2;
    settle();
    check("irq", {7'h0, irq}, 8'h01);
    check("wakeup", {7'h0, wake}, 8'h01);
    wr(smc_pkg::OFF_STATUS, k_ie);
    rd(smc_pkg::OFF_STATUS, k_low | k_flg | k_ie);
    wr(smc_pkg::OFF_STATUS, k_ie | k_ack);
    rd(smc_pkg::OFF_STATUS, k_low | k_ie);
    check("irq", {7'h0, irq}, 8'h00);
    wr(smc_pkg::OFF_STATUS, k_flg);
    rd(smc_pkg::OFF_STATUS, k_low);
    level <= 2'h1;
    settle();
    rd(smc_pkg::OFF_STATUS, k_low);
    level <= 2'h0;
    settle();
    rd(smc_pkg::OFF_STATUS, k_flg);
    check("irq", {7'h0, irq}, 8'h00);
    wr(smc_pkg::OFF_STATUS, k_ack);
    i_stop_mode <= 1'b1;
    rd(smc_pkg::OFF_STATUS, 8'h00);
    check("cmp_enable", {7'h0, cmp_en}, 8'h00);
    wr(smc_pkg::OFF_CONFIG_ONE, k_rsd | k_stp);
    rd(smc_pkg::OFF_CONFIG_ONE, k_rsd | k_stp);
    check("cmp_enable", {7'h0, cmp_en}, 8'h01);
    i_stop_mode <= 1'b0;
    i_wait_mode <= 1'b0;
    wr(smc_pkg::OFF_STATUS, k_ie);
    wr(smc_pkg::OFF_CONFIG_ONE, 8'h00);
    level <= 2'h2;
    settle();
    check("reset_req", {7'h0, rst_req}, 8'h01);
    check("pin_oe", {7'h0, pin_oe}, 8'h01);
    check("pin_level", {7'h0, pin_n}, 8'h00);
    check("wakeup", {7'h0, wake}, 8'h01);
    check("irq", {7'h0, irq}, 8'h00);
    rd(smc_pkg::OFF_STATUS, k_low | k_flg);
    level <= 2'h1;
    settle();
    check("reset_req", {7'h0, rst_req}, 8'h01);
    level <= 2'h0;
    settle();
    check("reset_req", {7'h0, rst_req}, 8'h00);
    check("pin_oe", {7'h0, pin_oe}, 8'h00);
    rd(smc_pkg::OFF_STATUS, k_flg);
    wr(smc_pkg::OFF_CONFIG_ONE, k_rsd | k_stp);
    wr(smc_pkg::OFF_STATUS, k_ie | k_ack);
    i_stop_mode <= 1'b1;
    level <= 2'h2;
    settle();
    check("irq", {7'h0, irq}, 8'h01);
    check("wakeup", {7'h0, wake}, 8'h01);
    rd(smc_pkg::OFF_STATUS, k_low | k_flg | k_ie);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(smc_pkg::OFF_STATUS, smc_pkg::RST_STATUS);
    rd(smc_pkg::OFF_CONFIG_ONE, smc_pkg::RST_CONFIG_ONE);
    rd(smc_pkg::OFF_CONFIG_TWO, {6'h0, smc_pkg::RST_RANGE});
    check("cmp_enable", {7'h0, cmp_en}, 8'h00);
    settle();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
